// file: fab_host_model.sv
// Purpose: host processor model driving the register port and transfer strobes
// Assumes: strobes change by non-blocking assignment after a rising edge
// Notes:   released address and data lines show the inverse of the last value
module fab_host_model (
  input wire logic clk_sys,
  input wire logic [15:0] reg_rdata,
  output logic [15:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  output logic op_start,
  output logic sector_done
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle bus at time zero
  initial begin
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    op_start = 1'b0;
    sector_done = 1'b0;
  end

  // one strobe cycle; lines inverted on release so stale values never match
  task automatic pulse_bus(input logic [15:0] addr, input logic [15:0] data, input logic is_wr);
    @(posedge clk_sys);
    reg_addr <= addr;
    reg_wdata <= data;
    reg_wr <= is_wr;
    reg_rd <= !is_wr;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_addr <= ~addr;
    reg_wdata <= ~data;
    #1;
  endtask : pulse_bus

  task automatic bus_wr(input logic [15:0] addr, input logic [15:0] data);
    pulse_bus(addr, data, 1'b1);
  endtask : bus_wr

  // read data stands only in the cycle after the strobe
  task automatic bus_rd(input logic [15:0] addr, output logic [15:0] data);
    pulse_bus(addr, 16'h0000, 1'b0);
    data = reg_rdata;
  endtask : bus_rd

  // callers start a transfer only once the previous one has finished
  task automatic pulse_ctl(input logic is_start);
    @(posedge clk_sys);
    op_start <= is_start;
    sector_done <= !is_start;
    @(posedge clk_sys);
    op_start <= 1'b0;
    sector_done <= 1'b0;
    #1;
  endtask : pulse_ctl
endmodule : fab_host_model

// file: fab_pkg.sv
// Purpose: shared constants for the flash address and buffer register group
// Assumes: 16-bit word-addressed register port, offsets are word addresses
// Notes:   design offsets, field positions and reset values live here; bench and checker use literals

package fab_pkg;

  // ----------------------------------------------------------------
  // register offsets (word addresses)
  // ----------------------------------------------------------------
  localparam logic [15:0] FAB_OFS_VERSION_INFO = 16'hf002;
  localparam logic [15:0] FAB_OFS_PAGE_BUF_CAP = 16'hf003;
  localparam logic [15:0] FAB_OFS_START_BUF_CAP = 16'hf004;
  localparam logic [15:0] FAB_OFS_BUFFER_COUNTS = 16'hf005;
  localparam logic [15:0] FAB_OFS_ARRAY_ARRAY_CELL_TYPE = 16'hf006;
  localparam logic [15:0] FAB_OFS_SRC_BLOCK = 16'hf100;
  localparam logic [15:0] FAB_OFS_SPARE_A = 16'hf101;
  localparam logic [15:0] FAB_OFS_CB_BLOCK = 16'hf102;
  localparam logic [15:0] FAB_OFS_CB_PAGE_SECTOR = 16'hf103;
  localparam logic [15:0] FAB_OFS_SPARE_B = 16'hf104;
  localparam logic [15:0] FAB_OFS_SPARE_C = 16'hf105;
  localparam logic [15:0] FAB_OFS_SPARE_D = 16'hf106;
  localparam logic [15:0] FAB_OFS_SRC_PAGE_SECTOR = 16'hf107;
  localparam logic [15:0] FAB_OFS_BUF_SELECT_COUNT = 16'hf200;
  localparam logic [15:0] FAB_OFS_WALK_STATUS = 16'hf201;

  // ----------------------------------------------------------------
  // constant register contents
  // ----------------------------------------------------------------
  localparam logic [15:0] FAB_VAL_PAGE_BUF_CAP = 16'h0800;
  localparam logic [15:0] FAB_VAL_START_BUF_CAP = 16'h0200;
  localparam logic [15:0] FAB_VAL_BUFFER_COUNTS = 16'h0201;
  localparam logic [15:0] FAB_VAL_ARRAY_ARRAY_CELL_TYPE = 16'h0000;
  localparam logic [15:0] FAB_VAL_RESERVED = 16'h0000;

  // ----------------------------------------------------------------
  // reset values of the writable registers
  // ----------------------------------------------------------------
  localparam logic [15:0] FAB_RST_SRC_BLOCK = 16'h0000;
  localparam logic [15:0] FAB_RST_CB_BLOCK = 16'h0000;
  localparam logic [15:0] FAB_RST_CB_PAGE_SECTOR = 16'h0000;
  localparam logic [15:0] FAB_RST_SRC_PAGE_SECTOR = 16'h0000;
  localparam logic [15:0] FAB_RST_BUF_SELECT_COUNT = 16'h0000;

  // ----------------------------------------------------------------
  // field widths and positions
  // ----------------------------------------------------------------
  localparam int FAB_BLOCK_W = 9;
  localparam int FAB_PAGE_W = 6;
  localparam int FAB_SECTOR_W = 2;
  localparam int FAB_SEL_W = 4;
  localparam int FAB_CNT_W = 2;
  localparam int FAB_LEFT_W = 3;
  localparam int FAB_BLOCK_LSB = 0;
  localparam int FAB_PAGE_LSB = 2;
  localparam int FAB_SECTOR_LSB = 0;
  localparam int FAB_SEL_LSB = 8;
  localparam int FAB_CNT_LSB = 0;
  localparam int FAB_SEL_MEM_BIT = 3;
  localparam int FAB_SEL_BANK_BIT = 2;
  localparam int FAB_ST_BUSY_BIT = 15;
  localparam int FAB_ST_CLAMP_BIT = 14;
  localparam int FAB_ST_SECTOR_LSB = 8;
  localparam int FAB_ST_LEFT_LSB = 0;

  // code 00 of the sector count stands for a full page of sectors
  localparam logic [2:0] FAB_FULL_PAGE_SECTORS = 3'h4;

endpackage : fab_pkg

// file: fab_regs.sv
// Purpose: host register group holding flash and buffer ram addresses
// Assumes: plain word-addressed port, read data one cycle after the strobe
// Notes:   the operation engine drives op_start and sector_done on clk_sys

// Notes on behaviour
// - page buffer capacity reads 0800h always: two buffers of 1024 words.
// - startup buffer capacity reads 0200h always: one buffer of 512 words.
// - buffer counts reads 0201h: two page buffers high, one startup low.
// - array technology reads 0000h, single level cell; 0001h would be multi.
// - source block register holds a 9-bit block index, upper bits zero.
// - copy-back block register holds a 9-bit destination block index.
// - copy-back page/sector holds 6-bit page over 2-bit sector, reset zero.
// - source page/sector holds 6-bit start page over 2-bit start sector.
// - sector count codes 1..3 mean that many sectors, code 00 means four.
// - multi-sector walk steps only low two select bits, wrapping 11 to 00 in page memory, 01 to 00 in startup memory.
// - select bit 3 picks memory kind, bit 2 page bank, bits 1:0 sector.
// - startup memory allows sectors 0 and 1, page memory 0 through 3.
// - buffer select register resets to 0000h; reserved bits read zero.
module fab_regs
  import fab_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic op_start,
  input wire logic sector_done,
  output logic [8:0] src_block_index,
  output logic [5:0] src_page_index,
  output logic [1:0] src_sector_index,
  output logic [8:0] dest_block_index,
  output logic [5:0] dest_page_index,
  output logic [1:0] dest_sector_index,
  output logic [3:0] ram_sector_select,
  output logic [1:0] ram_sector_count,
  output logic [3:0] ram_sector,
  output logic ram_is_page_memory,
  output logic ram_page_bank,
  output logic [1:0] ram_sector_in_buffer,
  output logic [2:0] sectors_left,
  output logic xfer_busy,
  output logic xfer_finished
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [8:0] src_block_index;
    logic [8:0] dest_block_index;
    logic [5:0] dest_page_index;
    logic [1:0] dest_sector_index;
    logic [5:0] src_page_index;
    logic [1:0] src_sector_index;
    logic [3:0] ram_sector_select;
    logic [1:0] ram_sector_count;
    logic [15:0] rdata;
  } fab_regs_state_t;

  fab_regs_state_t st;
  fab_regs_state_t next_st;

  // walker outputs, all registered inside the walker
  logic [3:0] walk_sector;
  logic [2:0] walk_left;
  logic walk_busy;
  logic walk_finished;
  logic walk_clamped;

  // write strobes per writable register
  logic wr_src_block;
  logic wr_cb_block;
  logic wr_cb_page_sector;
  logic wr_src_page_sector;
  logic wr_buf_select;

  // read value gathered before it is registered
  logic [15:0] read_value;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // page over sector layout shared by source and copy-back registers
  function automatic logic [15:0] pack_page_sector(
    input logic [5:0] page,
    input logic [1:0] sector
  );
    pack_page_sector = 16'h0000;
    pack_page_sector[FAB_PAGE_LSB +: FAB_PAGE_W] = page;
    pack_page_sector[FAB_SECTOR_LSB +: FAB_SECTOR_W] = sector;
  endfunction : pack_page_sector

  // nine-bit block index in the low bits, the rest zero
  function automatic logic [15:0] pack_block(input logic [8:0] block);
    pack_block = 16'h0000;
    pack_block[FAB_BLOCK_LSB +: FAB_BLOCK_W] = block;
  endfunction : pack_block

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  // only the five writable registers get a strobe; everything else,
  // constants and reserved slots alike, simply has no write path
  assign wr_src_block = reg_wr && (reg_addr == FAB_OFS_SRC_BLOCK);
  assign wr_cb_block = reg_wr && (reg_addr == FAB_OFS_CB_BLOCK);
  assign wr_cb_page_sector = reg_wr && (reg_addr == FAB_OFS_CB_PAGE_SECTOR);
  assign wr_src_page_sector = reg_wr && (reg_addr == FAB_OFS_SRC_PAGE_SECTOR);
  assign wr_buf_select = reg_wr && (reg_addr == FAB_OFS_BUF_SELECT_COUNT);

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  // unmapped and reserved words answer zero rather than floating data
  always_comb begin
    read_value = FAB_VAL_RESERVED;
    case (reg_addr)
      FAB_OFS_VERSION_INFO: begin
        read_value = FAB_VAL_RESERVED;
      end
      FAB_OFS_PAGE_BUF_CAP: begin
        read_value = FAB_VAL_PAGE_BUF_CAP;
      end
      FAB_OFS_START_BUF_CAP: begin
        read_value = FAB_VAL_START_BUF_CAP;
      end
      FAB_OFS_BUFFER_COUNTS: begin
        read_value = FAB_VAL_BUFFER_COUNTS;
      end
      FAB_OFS_ARRAY_ARRAY_CELL_TYPE: begin
        read_value = FAB_VAL_ARRAY_ARRAY_CELL_TYPE;
      end
      FAB_OFS_SRC_BLOCK: begin
        read_value = pack_block(st.src_block_index);
      end
      FAB_OFS_CB_BLOCK: begin
        read_value = pack_block(st.dest_block_index);
      end
      FAB_OFS_CB_PAGE_SECTOR: begin
        read_value = pack_page_sector(st.dest_page_index,
                                      st.dest_sector_index);
      end
      FAB_OFS_SRC_PAGE_SECTOR: begin
        read_value = pack_page_sector(st.src_page_index,
                                      st.src_sector_index);
      end
      FAB_OFS_BUF_SELECT_COUNT: begin
        // reserved bits between and above the fields stay zero
        read_value[FAB_SEL_LSB +: FAB_SEL_W] = st.ram_sector_select;
        read_value[FAB_CNT_LSB +: FAB_CNT_W] = st.ram_sector_count;
      end
      FAB_OFS_WALK_STATUS: begin
        // live view of the sector walk for software polling
        read_value[FAB_ST_BUSY_BIT] = walk_busy;
        read_value[FAB_ST_CLAMP_BIT] = walk_clamped;
        read_value[FAB_ST_SECTOR_LSB +: FAB_SEL_W] = walk_sector;
        read_value[FAB_ST_LEFT_LSB +: FAB_LEFT_W] = walk_left;
      end
      FAB_OFS_SPARE_A, FAB_OFS_SPARE_B, FAB_OFS_SPARE_C, FAB_OFS_SPARE_D: begin
        read_value = FAB_VAL_RESERVED;
      end
      default: begin
        read_value = FAB_VAL_RESERVED;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // read data stands only in the cycle after the strobe, zero otherwise,
  // so a stale value can never be mistaken for a fresh answer
  always_comb begin
    next_st = st;
    next_st.rdata = reg_rd ? read_value : 16'h0000;
    if (wr_src_block) begin
      next_st.src_block_index = reg_wdata[FAB_BLOCK_LSB +: FAB_BLOCK_W];
    end
    if (wr_cb_block) begin
      next_st.dest_block_index = reg_wdata[FAB_BLOCK_LSB +: FAB_BLOCK_W];
    end
    if (wr_cb_page_sector) begin
      next_st.dest_page_index = reg_wdata[FAB_PAGE_LSB +: FAB_PAGE_W];
      next_st.dest_sector_index = reg_wdata[FAB_SECTOR_LSB +: FAB_SECTOR_W];
    end
    if (wr_src_page_sector) begin
      next_st.src_page_index = reg_wdata[FAB_PAGE_LSB +: FAB_PAGE_W];
      next_st.src_sector_index = reg_wdata[FAB_SECTOR_LSB +: FAB_SECTOR_W];
    end
    if (wr_buf_select) begin
      // stored as written; the startup sector limit is applied by the walk
      next_st.ram_sector_select = reg_wdata[FAB_SEL_LSB +: FAB_SEL_W];
      next_st.ram_sector_count = reg_wdata[FAB_CNT_LSB +: FAB_CNT_W];
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st.src_block_index <= FAB_RST_SRC_BLOCK[FAB_BLOCK_LSB +: FAB_BLOCK_W];
      st.dest_block_index <= FAB_RST_CB_BLOCK[FAB_BLOCK_LSB +: FAB_BLOCK_W];
      st.dest_page_index <= FAB_RST_CB_PAGE_SECTOR[FAB_PAGE_LSB +: FAB_PAGE_W];
      st.dest_sector_index <= FAB_RST_CB_PAGE_SECTOR[FAB_SECTOR_LSB +: FAB_SECTOR_W];
      st.src_page_index <= FAB_RST_SRC_PAGE_SECTOR[FAB_PAGE_LSB +: FAB_PAGE_W];
      st.src_sector_index <= FAB_RST_SRC_PAGE_SECTOR[FAB_SECTOR_LSB +: FAB_SECTOR_W];
      st.ram_sector_select <= FAB_RST_BUF_SELECT_COUNT[FAB_SEL_LSB +: FAB_SEL_W];
      st.ram_sector_count <= FAB_RST_BUF_SELECT_COUNT[FAB_CNT_LSB +: FAB_CNT_W];
      st.rdata <= 16'h0000;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // sector walk
  // ----------------------------------------------------------------
  // the host is trusted to start an operation only after the walker has cleared
  // the busy flag, so op_start is never expected mid-walk
  fab_sector_walker u_walker (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .op_start(op_start),
    .sector_done(sector_done),
    .start_select(st.ram_sector_select),
    .start_count(st.ram_sector_count),
    .ram_sector(walk_sector),
    .sectors_left(walk_left),
    .busy(walk_busy),
    .finished(walk_finished),
    .clamped(walk_clamped)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // register contents for the operation engine
  assign reg_rdata = st.rdata;
  assign src_block_index = st.src_block_index;
  assign src_page_index = st.src_page_index;
  assign src_sector_index = st.src_sector_index;
  assign dest_block_index = st.dest_block_index;
  assign dest_page_index = st.dest_page_index;
  assign dest_sector_index = st.dest_sector_index;
  assign ram_sector_select = st.ram_sector_select;
  assign ram_sector_count = st.ram_sector_count;

  // decoded view of the current buffer ram sector
  assign ram_sector = walk_sector;
  assign ram_is_page_memory = walk_sector[FAB_SEL_MEM_BIT];
  assign ram_page_bank = walk_sector[FAB_SEL_BANK_BIT];
  assign ram_sector_in_buffer = walk_sector[1:0];
  assign sectors_left = walk_left;
  assign xfer_busy = walk_busy;
  assign xfer_finished = walk_finished;

endmodule : fab_regs

// file: fab_regs_props.sv
// Purpose: assertion checker for the flash address and buffer register group
// Assumes: sees only the ports of fab_regs, one clock domain
// Notes:   read data is judged in the cycle after the read strobe
module fab_regs_props (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic op_start,
  input wire logic sector_done,
  input wire logic [8:0] src_block_index,
  input wire logic [1:0] ram_sector_count,
  input wire logic [3:0] ram_sector,
  input wire logic ram_is_page_memory,
  input wire logic ram_page_bank,
  input wire logic [1:0] ram_sector_in_buffer,
  input wire logic [2:0] sectors_left,
  input wire logic xfer_busy,
  input wire logic xfer_finished
);
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  // ----------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------
  sequence s_rd(logic [15:0] a);
    reg_rd && reg_addr == a;
  endsequence
  sequence s_start;
    op_start && !xfer_busy;
  endsequence
  sequence s_last;
    sector_done && xfer_busy && sectors_left == 3'h1;
  endsequence

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_page_cap;
    s_rd(16'hf003) |=> reg_rdata == 16'h0800;
  endproperty
  property p_start_cap;
    s_rd(16'hf004) |=> reg_rdata == 16'h0200;
  endproperty
  property p_counts;
    s_rd(16'hf005) |=> reg_rdata == 16'h0201;
  endproperty
  property p_array_cell_type;
    s_rd(16'hf006) |=> reg_rdata == 16'h0000;
  endproperty
  // reserved slots must stay silent even after writes
  property p_reserved;
    reg_rd && (reg_addr == 16'hf002 || reg_addr == 16'hf101 || (reg_addr >= 16'hf104 && reg_addr <= 16'hf106))
      |=> reg_rdata == 16'h0000;
  endproperty
  property p_src_wr;
    logic [8:0] d;
    (reg_wr && reg_addr == 16'hf100, d = reg_wdata[8:0]) |=> src_block_index == d;
  endproperty
  property p_count;
    logic [1:0] c;
    (s_start, c = ram_sector_count) |=> xfer_busy && sectors_left == ((c == 2'h0) ? 3'h4 : {1'b0, c});
  endproperty
  // page memory walk: low bits step and wrap, select bits kept
  property p_step;
    logic [3:0] s;
    (sector_done && xfer_busy && sectors_left != 3'h1 && ram_sector[3], s = ram_sector)
      |=> ram_sector == {s[3:2], s[1:0] + 2'h1};
  endproperty
  property p_startup;
    xfer_busy && !ram_sector[3] |-> !ram_sector[1];
  endproperty
  property p_decode;
    ram_is_page_memory == ram_sector[3] && ram_page_bank == ram_sector[2] && ram_sector_in_buffer == ram_sector[1:0];
  endproperty
  property p_finish;
    s_last |=> !xfer_busy && xfer_finished && sectors_left == 3'h0 ##1 !xfer_finished;
  endproperty

  a_page_cap: assert property (p_page_cap)
    else $error("page buffer capacity wrong");
  a_start_cap: assert property (p_start_cap)
    else $error("startup buffer capacity wrong");
  a_counts: assert property (p_counts)
    else $error("buffer counts wrong");
  a_array_cell_type: assert property (p_array_cell_type)
    else $error("array technology wrong");
  a_reserved: assert property (p_reserved)
    else $error("reserved register not zero");
  a_src_wr: assert property (p_src_wr)
    else $error("source block not updated");
  a_count: assert property (p_count)
    else $error("sector count decode wrong");
  a_step: assert property (p_step)
    else $error("sector step wrong");
  a_startup: assert property (p_startup)
    else $error("startup memory sector out of range");
  a_decode: assert property (p_decode)
    else $error("sector select decode wrong");
  a_finish: assert property (p_finish)
    else $error("walk did not finish properly");
endmodule : fab_regs_props

bind fab_regs fab_regs_props i_props (.clk_sys, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .op_start, .sector_done, .src_block_index, .ram_sector_count, .ram_sector, .ram_is_page_memory,
  .ram_page_bank, .ram_sector_in_buffer, .sectors_left, .xfer_busy, .xfer_finished);

// file: fab_sector_walker.sv
// Purpose: walks the buffer ram sector address during a multi-sector transfer
// Assumes: op_start and sector_done come from logic on clk_sys
// Notes:   settings are snapshotted at start, so later writes do not disturb

module fab_sector_walker
  import fab_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic op_start,
  input wire logic sector_done,
  input wire logic [3:0] start_select,
  input wire logic [1:0] start_count,
  output logic [3:0] ram_sector,
  output logic [2:0] sectors_left,
  output logic busy,
  output logic finished,
  output logic clamped
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic {WALK_IDLE, WALK_RUN} fab_walk_fsm_t;

  typedef struct packed {
    fab_walk_fsm_t fsm;
    logic [3:0] sel;
    logic [2:0] left;
    logic done;
    logic clamp;
  } fab_walk_state_t;

  fab_walk_state_t st;
  fab_walk_state_t next_st;

  // count code to number of sectors, 00 meaning four
  function automatic logic [2:0] sectors_of(input logic [1:0] code);
    sectors_of = (code == 2'h0) ? FAB_FULL_PAGE_SECTORS : {1'b0, code};
  endfunction : sectors_of

  // startup memory only has sectors 0 and 1, page memory 0 to 3
  function automatic logic [3:0] legal_sector(input logic [3:0] sel);
    legal_sector = sel;
    if (!sel[FAB_SEL_MEM_BIT]) begin
      legal_sector[1] = 1'b0;
    end
  endfunction : legal_sector

  // advance only the low sector bits; the memory select bits stay put
  function automatic logic [3:0] step_sector(input logic [3:0] sel);
    step_sector = {sel[3:2], sel[1:0] + 2'h1};
    step_sector = legal_sector(step_sector);
  endfunction : step_sector

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    case (st.fsm)
      WALK_IDLE: begin
        if (op_start) begin
          next_st.fsm = WALK_RUN;
          next_st.sel = legal_sector(start_select);
          next_st.clamp = ~start_select[FAB_SEL_MEM_BIT] & start_select[1];
          next_st.left = sectors_of(start_count);
        end
      end
      WALK_RUN: begin
        // a start while running is ignored: one operation at a time
        if (sector_done) begin
          if (st.left == 3'h1) begin
            next_st.fsm = WALK_IDLE;
            next_st.left = 3'h0;
            next_st.done = 1'b1;
          end else begin
            next_st.left = st.left - 3'h1;
            next_st.sel = step_sector(st.sel);
          end
        end
      end
      default: begin
        next_st.fsm = WALK_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st <= '{fsm: WALK_IDLE, sel: 4'h0, left: 3'h0, done: 1'b0, clamp: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign ram_sector = st.sel;
  assign sectors_left = st.left;
  assign busy = (st.fsm == WALK_RUN);
  assign finished = st.done;
  assign clamped = st.clamp;

endmodule : fab_sector_walker

// file: tb.sv
// Purpose: self-checking bench for the flash address and buffer register group
// Assumes: host model drives the register port and transfer strobes; the bench drives clk_sys and resetn
// Notes:   expected values come from the register map, not from the design
module tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk_sys = 1'b0;
  logic resetn;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, seen;
  logic reg_wr, reg_rd, op_start, sector_done;
  logic [8:0] src_block_index, dest_block_index;
  logic [5:0] src_page_index, dest_page_index;
  logic [1:0] src_sector_index, dest_sector_index, ram_sector_count, ram_sector_in_buffer;
  logic [3:0] ram_sector_select, ram_sector;
  logic [2:0] sectors_left;
  logic ram_is_page_memory, ram_page_bank, xfer_busy, xfer_finished;
  int bad_count = 0;
  int n_tests = 0;

  // register map: address, value after reset, value after writing all ones
  localparam logic [15:0] ADDRS [15] = '{16'hf002, 16'hf003, 16'hf004, 16'hf005, 16'hf006, 16'hf100,
    16'hf101, 16'hf102, 16'hf103, 16'hf104, 16'hf105, 16'hf106, 16'hf107, 16'hf200, 16'hf0ff};
  localparam logic [15:0] EXP_RST [15] = '{16'h0, 16'h0800, 16'h0200, 16'h0201, 16'h0, 16'h0,
    16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
  localparam logic [15:0] EXP_ONES [15] = '{16'h0, 16'h0800, 16'h0200, 16'h0201, 16'h0, 16'h01ff,
    16'h0, 16'h01ff, 16'h00ff, 16'h0, 16'h0, 16'h0, 16'h00ff, 16'h0f03, 16'h0};

  always #12.5 clk_sys = ~clk_sys;

  fab_regs i_dut (.clk_sys, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .op_start,
    .sector_done, .src_block_index, .src_page_index, .src_sector_index, .dest_block_index,
    .dest_page_index, .dest_sector_index, .ram_sector_select, .ram_sector_count, .ram_sector,
    .ram_is_page_memory, .ram_page_bank, .ram_sector_in_buffer, .sectors_left, .xfer_busy, .xfer_finished);

  fab_host_model i_host (.clk_sys, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .op_start,
    .sector_done);

  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // seq holds the expected sectors, first one in the top nibble
  task automatic walk(input logic [3:0] sel, input logic [1:0] cnt, input logic [15:0] seq);
    int n;
    n = (cnt == 2'h0) ? 4 : int'(cnt);
    i_host.bus_wr(16'hf200, {4'h0, sel, 6'h00, cnt});
    i_host.pulse_ctl(1'b1);
    // status word: busy, clamp on a startup select with bit 1 set, first sector, count
    i_host.bus_rd(16'hf201, seen);
    check("walk status", seen, {1'b1, ~sel[3] & sel[1], 2'h0, seq[15:12], 5'h00, 3'(n)});
    for (int k = 0; k < n; k++) begin
      check("ram sector", {28'h0, ram_sector}, {28'h0, seq[15 - 4 * k -: 4]});
      check("sectors left", {29'h0, sectors_left}, 32'(n - k));
      i_host.pulse_ctl(1'b0);
    end
    check("finish flags", {30'h0, xfer_busy, xfer_finished}, 32'h1);
  endtask : walk

  task automatic tally_and_finish();
    if (bad_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    for (int i = 0; i < 15; i++) begin
      i_host.bus_rd(ADDRS[i], seen);
      check("reset read", seen, EXP_RST[i]);
    end
    // all ones exposes both the field masks and the ignored writes
    for (int i = 0; i < 15; i++) begin
      i_host.bus_wr(ADDRS[i], 16'hffff);
    end
    for (int i = 0; i < 15; i++) begin
      i_host.bus_rd(ADDRS[i], seen);
      check("ones read", seen, EXP_ONES[i]);
    end
    check("source ports", {src_block_index, src_page_index, src_sector_index}, 32'h1ffff);
    check("dest ports", {dest_block_index, dest_page_index, dest_sector_index}, 32'h1ffff);
    check("buffer ports", {ram_sector_select, ram_sector_count}, 32'h3f);
    walk(4'hd, 2'h0, 16'hdefc);
    walk(4'h4, 2'h1, 16'h4000);
    walk(4'h6, 2'h2, 16'h4500);
    walk(4'hb, 2'h3, 16'hb890);
    walk(4'h3, 2'h0, 16'h1010);
    tally_and_finish();
  end

  // watchdog well beyond the roughly 150 cycles the tests need
  initial begin
    #50000;
    bad_count++;
    tally_and_finish();
  end
endmodule : tb
